// ===== core/pmc_defs.svh
// Constants for the dual core power mode controller
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_NUM_CORES 2
`define PMC_NUM_BLOCKS 8
`define PMC_RST_TIME_NS 400
`define PMC_CLK_NS 40
`define PMC_RST_CYCLES ((`PMC_RST_TIME_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_MODE_DEEP_SLEEP 2'h0
`define PMC_MODE_POWER_DOWN 2'h1
`define PMC_MODE_DEEP_PD 2'h2
`endif

// ===== core/pmc_pkg.sv
// Types for the dual core power mode controller
package pmc_pkg;
    typedef enum logic [2:0] {
        PMC_ACTIVE = 3'h0,
        PMC_SLEEP = 3'h1,
        PMC_DEEP_SLEEP = 3'h3,
        PMC_POWER_DOWN = 3'h2,
        PMC_DEEP_PD = 3'h6
    } pmc_state_t;
    typedef enum logic [1:0] {
        PMC_SYS_RUN = 2'h0,
        PMC_SYS_LOW = 2'h1,
        PMC_SYS_WAKE = 2'h3,
        PMC_SYS_RESET = 2'h2
    } pmc_sys_t;
    typedef struct packed {
        logic [1:0] core_clk_en;
        logic periph_clk_en;
        logic periph_pwr_en;
        logic mem_pwr_en;
        logic chip_reset;
    } pmc_pwr_t;
endpackage

// ===== core/pmc_power_mode_controller.sv
// Power mode sequencer for two cores with per-block reset generator
`timescale 1ns/10ps
`default_nettype none
`include "pmc_defs.svh"
module pmc_power_mode_controller (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] core_sleep_req,
    input wire logic [1:0] wait_instr,
    input wire logic [1:0] pd_req_en,
    input wire logic [1:0] pd_req,
    input wire logic [1:0] pd_mode_sel,
    input wire logic [1:0] core_interrupt_controller,
    input wire logic [1:0] event_in,
    input wire logic wake_pin,
    input wire logic rtc_event,
    input wire logic alarm_event,
    input wire logic [7:0] block_rst_req,
    output logic [1:0] core_clk_en,
    output logic [1:0] core_active,
    output logic [1:0] wake_irq_pending,
    output logic [1:0] wake_evt_pending,
    output logic periph_clk_en,
    output logic periph_pwr_en,
    output logic mem_pwr_en,
    output logic chip_reset,
    output logic [2:0] sys_mode,
    output logic [7:0] block_rst
);
    import pmc_pkg::*;

    pmc_state_t core_state_reg [2];
    pmc_sys_t sys_reg;
    logic [1:0] pd_mode_reg;
    logic [1:0] pend_reg;
    logic [3:0] rst_cnt_reg;
    logic [1:0] armed;
    logic all_agree;
    logic sys_wake;
    logic sys_run;
    logic deep_pd_sel;

    // An enabled active core arms only while it waits
    assign armed = pd_req_en & pd_req & wait_instr & core_active;
    // Every enabled core must have armed
    assign all_agree = (pd_req_en != 2'h0) &&
        ((armed & pd_req_en) == pd_req_en);
    assign sys_wake = wake_pin | rtc_event | alarm_event;
    // Sequencer idle, system running
    assign sys_run = (sys_reg == PMC_SYS_RUN);
    // Codes above power-down all act as deep power-down
    assign deep_pd_sel = (pd_mode_reg >= `PMC_MODE_DEEP_PD);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_core
            // Latch wake sources apart; set wins over clear
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    wake_irq_pending[gi] <= 1'b0;
                    wake_evt_pending[gi] <= 1'b0;
                end else begin
                    if (core_interrupt_controller[gi])
                        wake_irq_pending[gi] <= 1'b1;
                    else if (core_state_reg[gi] == PMC_ACTIVE)
                        wake_irq_pending[gi] <= 1'b0;
                    if (event_in[gi])
                        wake_evt_pending[gi] <= 1'b1;
                    else if (core_state_reg[gi] == PMC_ACTIVE)
                        wake_evt_pending[gi] <= 1'b0;
                end
            end
            // Per-core active or sleep
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    core_state_reg[gi] <= PMC_ACTIVE;
                end else if (sys_reg != PMC_SYS_RUN) begin
                    core_state_reg[gi] <= PMC_ACTIVE;
                end else begin
                    case (core_state_reg[gi])
                        PMC_ACTIVE: begin
                            if (core_sleep_req[gi] && !all_agree)
                                core_state_reg[gi] <= PMC_SLEEP;
                        end
                        PMC_SLEEP: begin
                            if (core_interrupt_controller[gi] ||
                                event_in[gi] || wake_irq_pending[gi] ||
                                wake_evt_pending[gi])
                                core_state_reg[gi] <= PMC_ACTIVE;
                        end
                        default: core_state_reg[gi] <= PMC_ACTIVE;
                    endcase
                end
            end
            // Clock only for a running active core
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    core_clk_en[gi] <= 1'b1;
                    core_active[gi] <= 1'b1;
                end else begin
                    core_clk_en[gi] <= (sys_reg == PMC_SYS_RUN) &&
                        (core_state_reg[gi] == PMC_ACTIVE) &&
                        !(core_sleep_req[gi] && !all_agree) &&
                        !all_agree;
                    core_active[gi] <= (sys_reg == PMC_SYS_RUN) &&
                        (core_state_reg[gi] == PMC_ACTIVE);
                end
            end
        end
    endgenerate

    // System low-power sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sys_reg <= PMC_SYS_RUN;
            pd_mode_reg <= `PMC_MODE_DEEP_SLEEP;
            rst_cnt_reg <= 4'h0;
        end else begin
            case (sys_reg)
                PMC_SYS_RUN: begin
                    // Mode latched at the moment of agreement
                    if (all_agree) begin
                        sys_reg <= PMC_SYS_LOW;
                        pd_mode_reg <= pd_mode_sel;
                    end
                end
                PMC_SYS_LOW: begin
                    if (sys_wake) begin
                        // Deep power-down wake runs the chip reset
                        if (deep_pd_sel) begin
                            sys_reg <= PMC_SYS_RESET;
                            rst_cnt_reg <= 4'(`PMC_RST_CYCLES);
                        end else begin
                            sys_reg <= PMC_SYS_WAKE;
                        end
                    end
                end
                PMC_SYS_WAKE: sys_reg <= PMC_SYS_RUN;
                PMC_SYS_RESET: begin
                    // Chip-wide reset clears the latched mode
                    pd_mode_reg <= `PMC_MODE_DEEP_SLEEP;
                    if (rst_cnt_reg == 4'h1)
                        sys_reg <= PMC_SYS_RUN;
                    rst_cnt_reg <= rst_cnt_reg - 4'h1;
                end
                default: sys_reg <= PMC_SYS_RUN;
            endcase
        end
    end

    // Domain power and clocks
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            periph_clk_en <= 1'b1;
            periph_pwr_en <= 1'b1;
            mem_pwr_en <= 1'b1;
            chip_reset <= 1'b0;
        end else begin
            // Peripheral domain off from entry until run again
            periph_clk_en <= sys_run && !all_agree;
            periph_pwr_en <= sys_run && !all_agree;
            // Memories keep power only in deep-sleep
            if (sys_reg == PMC_SYS_LOW)
                mem_pwr_en <= (pd_mode_reg == `PMC_MODE_DEEP_SLEEP);
            else if (sys_run && all_agree)
                mem_pwr_en <= (pd_mode_sel == `PMC_MODE_DEEP_SLEEP);
            else
                mem_pwr_en <= 1'b1;
            // Chip reset held while the wake count runs
            chip_reset <= (sys_reg == PMC_SYS_RESET);
        end
    end

    // Reported state, ranked by consumption
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sys_mode <= PMC_ACTIVE;
        end else if (sys_reg == PMC_SYS_LOW) begin
            // Low-power code follows the latched mode
            case (pd_mode_reg)
                `PMC_MODE_DEEP_SLEEP: sys_mode <= PMC_DEEP_SLEEP;
                `PMC_MODE_POWER_DOWN: sys_mode <= PMC_POWER_DOWN;
                default: sys_mode <= PMC_DEEP_PD;
            endcase
        end else if (core_state_reg[0] == PMC_SLEEP &&
                     core_state_reg[1] == PMC_SLEEP) begin
            sys_mode <= PMC_SLEEP;
        end else begin
            sys_mode <= PMC_ACTIVE;
        end
    end

    // Per-block resets, forced by a chip reset
    generate
        for (gi = 0; gi < `PMC_NUM_BLOCKS; gi = gi + 1) begin : g_rst
            always_ff @(posedge clk) begin
                if (sys_rst)
                    block_rst[gi] <= 1'b1;
                else
                    block_rst[gi] <= block_rst_req[gi] ||
                        (sys_reg == PMC_SYS_RESET);
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ===== sim/pmc_core_model.sv
// Two core model driving wait and request lines
`timescale 1ns/10ps
`default_nettype none
module pmc_core_model (
    input wire logic clk,
    input wire logic [1:0] want_pd,
    input wire logic [1:0] want_sleep,
    input wire logic [1:0] core_active,
    output var logic [1:0] wait_instr = 2'h0,
    output var logic [1:0] pd_req = 2'h0,
    output var logic [1:0] core_sleep_req = 2'h0
);
    always_ff @(posedge clk) begin
        pd_req <= want_pd & core_active;
        wait_instr <= want_pd | want_sleep;
        core_sleep_req <= want_sleep;
    end
endmodule
`default_nettype wire

// ===== sim/pmc_power_mode_controller_chk.sv
// Port checker for the power mode controller
`timescale 1ns/10ps
`default_nettype none
module pmc_power_mode_controller_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] core_sleep_req,
    input wire logic [1:0] wait_instr,
    input wire logic [1:0] pd_req_en,
    input wire logic [1:0] pd_req,
    input wire logic [1:0] pd_mode_sel,
    input wire logic [1:0] core_interrupt_controller,
    input wire logic wake_pin,
    input wire logic rtc_event,
    input wire logic alarm_event,
    input wire logic [1:0] core_clk_en,
    input wire logic [1:0] core_active,
    input wire logic periph_clk_en,
    input wire logic periph_pwr_en,
    input wire logic mem_pwr_en,
    input wire logic chip_reset,
    input wire logic [7:0] block_rst
);
    logic agree;
    logic wake;
    assign agree = pd_req_en != 2'h0
        && (pd_req_en & ~(pd_req & wait_instr & core_active)) == 2'h0;
    assign wake = wake_pin || rtc_event || alarm_event;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_entry_needs_agree: assert property (
        $fell(periph_pwr_en) && !chip_reset |-> $past(agree))
        else $error("low power entered without agreement");
    chk_enter_low: assert property (
        agree && periph_pwr_en && !chip_reset |=> core_clk_en == 2'h0
        && !periph_clk_en && !periph_pwr_en) else $error("entry missed");
    chk_mem_by_mode: assert property (
        $fell(periph_pwr_en) && !chip_reset
        |-> mem_pwr_en == ($past(pd_mode_sel) == 2'h0))
        else $error("memory power wrong for mode");
    chk_low_holds: assert property (
        (!periph_pwr_en && pd_mode_sel < 2'h2 && !wake) [*4]
        |=> !periph_pwr_en) else $error("left low power without wake");
    chk_wake_restore: assert property (
        wake && !periph_pwr_en && pd_mode_sel < 2'h2
        |-> ##[1:5] periph_pwr_en && core_active == 2'h3)
        else $error("wake did not restore system");
    chk_deep_pd_reset: assert property (
        wake && !periph_pwr_en && pd_mode_sel >= 2'h2 && !chip_reset
        |-> ##[1:3] chip_reset && block_rst == 8'hFF)
        else $error("deep power-down wake without reset");
    chk_sleep_keeps_periph: assert property (
        core_clk_en == 2'h1 || core_clk_en == 2'h2
        |-> periph_clk_en && mem_pwr_en) else $error("peripherals stopped");
    chk_core_wake: assert property (
        !core_clk_en[0] && periph_pwr_en && core_interrupt_controller[0]
        && !core_sleep_req[0] |-> ##[1:3] core_clk_en[0])
        else $error("core did not wake on interrupt");
endmodule
bind pmc_power_mode_controller pmc_power_mode_controller_chk u_chk (
    .clk(clk), .sys_rst(sys_rst), .core_sleep_req(core_sleep_req),
    .wait_instr(wait_instr), .pd_req_en(pd_req_en), .pd_req(pd_req),
    .pd_mode_sel(pd_mode_sel),
    .core_interrupt_controller(core_interrupt_controller),
    .wake_pin(wake_pin), .rtc_event(rtc_event), .alarm_event(alarm_event),
    .core_clk_en(core_clk_en), .core_active(core_active),
    .periph_clk_en(periph_clk_en), .periph_pwr_en(periph_pwr_en),
    .mem_pwr_en(mem_pwr_en), .chip_reset(chip_reset),
    .block_rst(block_rst));
`default_nettype wire

// ===== sim/pmc_power_mode_controller_tb.sv
// Testbench for the power mode controller
`timescale 1ns/10ps
`default_nettype none
module pmc_power_mode_controller_tb;
    import pmc_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] want_pd = 2'h0;
    logic [1:0] want_sleep = 2'h0;
    logic [1:0] pd_req_en = 2'h0;
    logic [1:0] pd_mode_sel = 2'h0;
    logic [1:0] irq = 2'h0;
    logic [1:0] evt = 2'h0;
    logic [2:0] wake_src = 3'h0;
    logic [7:0] block_rst_req = 8'h00;
    logic [1:0] sleep_req, wait_instr, pd_req, core_clk_en, core_active;
    logic periph_clk_en, periph_pwr_en, mem_pwr_en, chip_reset;
    logic [2:0] sys_mode;
    logic [7:0] block_rst;
    logic [1:0] irq_pend, evt_pend;
    int n_fail = 0;
    int n_tests = 0;
    always #20 clk = ~clk;
    pmc_core_model u_pmc_core_model (.clk(clk), .want_pd(want_pd),
        .want_sleep(want_sleep), .core_active(core_active),
        .wait_instr(wait_instr), .pd_req(pd_req), .core_sleep_req(sleep_req));
    pmc_power_mode_controller u_pmc_power_mode_controller (.clk(clk),
        .sys_rst(sys_rst), .core_sleep_req(sleep_req), .wait_instr(wait_instr),
        .pd_req_en(pd_req_en), .pd_req(pd_req), .pd_mode_sel(pd_mode_sel),
        .core_interrupt_controller(irq), .event_in(evt),
        .wake_pin(wake_src[0]), .rtc_event(wake_src[1]),
        .alarm_event(wake_src[2]), .block_rst_req(block_rst_req),
        .core_clk_en(core_clk_en), .core_active(core_active),
        .wake_irq_pending(irq_pend), .wake_evt_pending(evt_pend),
        .periph_clk_en(periph_clk_en), .periph_pwr_en(periph_pwr_en),
        .mem_pwr_en(mem_pwr_en), .chip_reset(chip_reset),
        .sys_mode(sys_mode), .block_rst(block_rst));
    task automatic check(string n, logic [8:0] s, logic [8:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic core_sleep();
        @(posedge clk);
        want_sleep <= 2'h3;
        repeat (5) @(posedge clk);
        #1 check("sleep", {core_clk_en, periph_clk_en, mem_pwr_en}, 4'h3);
        check("mode", sys_mode, PMC_SLEEP);
        @(posedge clk);
        want_sleep <= 2'h2;
        @(posedge clk);
        irq <= 2'h1;
        @(posedge clk);
        irq <= 2'h0;
        #1 check("irq_latch", irq_pend, 2'h1);
        repeat (3) @(posedge clk);
        #1 check("wake0", core_clk_en, 2'h1);
        @(posedge clk);
        want_sleep <= 2'h0;
        evt <= 2'h2;
        @(posedge clk);
        evt <= 2'h0;
        #1 check("evt_latch", evt_pend, 2'h2);
        repeat (3) @(posedge clk);
        #1 check("wake1", core_clk_en, 2'h3);
    endtask
    task automatic refuse();
        @(posedge clk);
        pd_req_en <= 2'h1;
        want_pd <= 2'h2;
        repeat (6) @(posedge clk);
        #1 check("refuse", {periph_pwr_en, sys_mode}, 4'h8);
        @(posedge clk);
        want_pd <= 2'h0;
        block_rst_req <= 8'hA5;
        repeat (2) @(posedge clk);
        #1 check("blk", block_rst, 8'hA5);
        @(posedge clk);
        block_rst_req <= 8'h00;
    endtask
    task automatic low_power(logic [1:0] m);
        @(posedge clk);
        pd_req_en <= 2'h3;
        pd_mode_sel <= m;
        want_pd <= 2'h1;
        repeat (6) @(posedge clk);
        #1 check("early", periph_pwr_en, 1'b1);
        @(posedge clk);
        want_pd <= 2'h3;
        repeat (5) @(posedge clk);
        #1 check("off", {core_clk_en, periph_clk_en, periph_pwr_en}, 4'h0);
        check("mem", mem_pwr_en, m == 2'h0);
        check("mode", sys_mode, m == 2'h0 ? PMC_DEEP_SLEEP :
            m == 2'h1 ? PMC_POWER_DOWN : PMC_DEEP_PD);
        @(posedge clk);
        irq <= 2'h3;
        @(posedge clk);
        irq <= 2'h0;
        want_pd <= 2'h0;
        repeat (3) @(posedge clk);
        #1 check("hold", periph_pwr_en, 1'b0);
        @(posedge clk);
        wake_src <= 3'h1 << (m == 2'h3 ? 2'h0 : m);
        @(posedge clk);
        wake_src <= 3'h0;
        if (m[1]) begin
            repeat (2) @(posedge clk);
            #1 check("crst", {chip_reset, block_rst}, 9'h1FF);
        end
        repeat (m[1] ? 16 : 4) @(posedge clk);
        #1 check("back", {core_active, core_clk_en, periph_pwr_en,
            mem_pwr_en, chip_reset}, 7'h7E);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check("run", {core_clk_en, core_active}, 4'hF);
        core_sleep();
        refuse();
        for (int m = 0; m < 4; m++) begin
            low_power(m[1:0]);
        end
        finish_test();
    end
    initial begin
        #40000;
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
